// [handshake_port_buffering_test.sv]
// handshake_port_buffering_test: register-level tests of hpb_port
// assumes hpb_peer drives the far side of the handshake lines
`timescale 1ns/1ps
`default_nettype none
module handshake_port_buffering_test;
  import hpb_pkg::*;
  logic          clk;
  logic          rst;
  logic          go;
  logic [7:0]    byte_val;
  logic [7:0]    low_len;
  logic [7:0]    seen;
  logic          irq;
  logic [31:0]   rd;
  hpb_av_req_s   av_req;
  hpb_av_rsp_s   av_rsp;
  hpb_link_in_s  link_in;
  hpb_link_out_s link_out;
  int            mismatches;
  int            n_checks;
  localparam logic [31:0] CLR = {24'h0, CMD_CLR_IP, 5'h00};

  hpb_port dut (.clk(clk), .rst(rst), .av_req(av_req), .av_rsp(av_rsp),
    .link_in(link_in), .link_out(link_out), .irq(irq));
  hpb_peer peer (.clk(clk), .rst(rst), .go(go), .byte_val(byte_val),
    .low_len(low_len), .link_out(link_out), .link_in(link_in), .seen(seen));

  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  task automatic conclude;
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // request held until waitrequest is sampled low
  // only the watchdog ends a wait that never completes
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    av_req <= '{address: a, read: !wr, write: wr, writedata: d};
    do
    begin
      @(posedge clk);
    end
    while (av_rsp.waitrequest !== 1'h0);
    rd = av_rsp.readdata;
    av_req <= '0;
    @(posedge clk);
  endtask

  // status bits {match, pending, empty, full} under mask m
  task automatic st(input logic [3:0] e, input logic [3:0] m);
    bus(1'h0, CMD_OFS, 32'h0);
    chk("status", {28'h0, e}, {28'h0, rd[3:0] & m});
  endtask

  task automatic xfer(input logic [7:0] b, input logic [7:0] l);
    byte_val <= b;
    low_len <= l;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
  endtask

  task automatic reset_dut;
    rst <= 1'h1;
    tick(3);
    rst <= 1'h0;
    tick(1);
  endtask

  initial
  begin
    #125000;
    mismatches++;
    conclude();
  end

  initial
  begin
    rst = 1'h1;
    av_req = '0;
    go = 1'h0;
    byte_val = 8'h00;
    low_len = 8'h00;
    mismatches = 0;
    n_checks = 0;
    tick(3);
    rst <= 1'h0;
    tick(1);
    chk("irq", 1'h0, irq);
    chk("oe_n", 1'h1, link_out.pins_oe_n);
    bus(1'h0, CFG_OFS, 32'h0);
    chk("cfg", {22'h0, CFG_RST}, rd);
    bus(1'h0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rd);
    // output port, interlocked
    bus(1'h1, CFG_OFS, 32'h301);
    tick(4);
    st(4'h0, 4'h4);
    bus(1'h1, DATA_OFS, 32'h5A);
    tick(2);
    st(4'h6, 4'h6);
    chk("pins", 8'h5A, link_out.pins_out);
    chk("oe_n", 1'h0, link_out.pins_oe_n);
    chk("dav", 1'h0, link_out.data_available_line);
    chk("irq", 1'h1, irq);
    bus(1'h1, DATA_OFS, 32'h33);
    st(4'h0, 4'h6);
    chk("irq", 1'h0, irq);
    xfer(8'h00, 8'h0A);
    tick(7);
    chk("dav", 1'h1, link_out.data_available_line);
    chk("seen", 8'h5A, seen);
    tick(10);
    chk("dav", 1'h0, link_out.data_available_line);
    chk("pins", 8'h33, link_out.pins_out);
    st(4'h6, 4'h6);
    bus(1'h1, CMD_OFS, CLR);
    st(4'h2, 4'h6);
    bus(1'h1, CFG_OFS, 32'h201);
    tick(2);
    chk("oe_n", 1'h1, link_out.pins_oe_n);
    // input port, interlocked then pulsed
    for (int k = 0; k < 2; k++)
    begin
      reset_dut();
      bus(1'h1, CFG_OFS, k ? 32'h304 : 32'h300);
      xfer(8'hC3, 8'h10);
      tick(6);
      chk("ready", 1'h0, link_out.ready_for_data_line);
      st(4'h1, 4'h1);
      tick(2);
      chk("ready", 1'h0, link_out.ready_for_data_line);
      bus(1'h0, DATA_OFS, 32'h0);
      chk("in_data", 8'hC3, rd[7:0]);
      tick(12);
      chk("ready", 1'h1, link_out.ready_for_data_line);
    end
    // strobed input: ready back while acknowledge still low
    reset_dut();
    bus(1'h1, CFG_OFS, 32'h302);
    xfer(8'h96, 8'h14);
    tick(8);
    chk("ready", 1'h1, link_out.ready_for_data_line);
    bus(1'h0, DATA_OFS, 32'h0);
    chk("in_data", 8'h96, rd[7:0]);
    tick(16);
    bus(1'h1, CFG_OFS, 32'h100);
    xfer(8'h44, 8'h06);
    tick(12);
    st(4'h0, 4'h1);
    // single buffer
    reset_dut();
    bus(1'h1, CFG_OFS, 32'h311);
    bus(1'h1, DATA_OFS, 32'h11);
    tick(2);
    chk("pins", 8'h11, link_out.pins_out);
    st(4'h0, 4'h2);
    xfer(8'h00, 8'h06);
    tick(12);
    st(4'h6, 4'h6);
    // two-byte pending
    reset_dut();
    bus(1'h1, CFG_OFS, 32'h309);
    bus(1'h1, DATA_OFS, 32'h01);
    bus(1'h1, DATA_OFS, 32'h02);
    st(4'h0, 4'h4);
    xfer(8'h00, 8'h06);
    tick(12);
    st(4'h0, 4'h4);
    xfer(8'h00, 8'h06);
    tick(12);
    st(4'h4, 4'h4);
    bus(1'h1, DATA_OFS, 32'h03);
    st(4'h0, 4'h4);
    // pattern match on the output move
    reset_dut();
    bus(1'h1, PAT_OFS, 32'hFF5A);
    bus(1'h1, CFG_OFS, 32'h321);
    bus(1'h1, DATA_OFS, 32'h5A);
    tick(2);
    st(4'hE, 4'hE);
    bus(1'h1, DATA_OFS, 32'h77);
    st(4'hE, 4'hE);
    bus(1'h1, CMD_OFS, CLR);
    st(4'h8, 4'hE);
    xfer(8'h00, 8'h06);
    tick(12);
    st(4'h6, 4'hE);
    // interrupt on match only
    reset_dut();
    bus(1'h1, PAT_OFS, 32'hFF5A);
    bus(1'h1, CFG_OFS, 32'h3A1);
    bus(1'h1, DATA_OFS, 32'h12);
    tick(2);
    chk("irq", 1'h0, irq);
    xfer(8'h00, 8'h06);
    tick(12);
    bus(1'h1, DATA_OFS, 32'h5A);
    tick(2);
    chk("irq", 1'h1, irq);
    conclude();
  end
endmodule
`default_nettype wire

// [hpb_peer.sv]
// hpb_peer: peripheral model on the handshake lines of one port
// assumes the bench starts one transfer at a time through go
`timescale 1ns/1ps
`default_nettype none
module hpb_peer
  import hpb_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // bench control
  input  wire logic                   go,
  input  wire logic [7:0]             byte_val,
  input  wire logic [7:0]             low_len,
  // handshake lines
  input  wire hpb_pkg::hpb_link_out_s link_out,
  output var  hpb_pkg::hpb_link_in_s  link_in,
  // byte seen at the acknowledge fall
  output logic [7:0]                  seen
);
  logic [7:0] cnt;

  // strobe width set by the bench, kept above the sync delay
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      link_in.pins_in <= 8'h00;
      link_in.ack_raw <= 1'h1;
      cnt <= 8'h00;
      seen <= 8'h00;
    end
    else if (go)
    begin
      link_in.pins_in <= byte_val;
      cnt <= low_len + 8'h01;
    end
    else if (cnt != 8'h00)
    begin
      link_in.ack_raw <= (cnt == 8'h01);
      cnt <= cnt - 8'h01;
      if (link_in.ack_raw)
        seen <= link_out.pins_out;
      // no pull on the pins: released data must not look valid
      if (cnt == 8'h01)
        link_in.pins_in <= ~link_in.pins_in;
    end
  end
endmodule
`default_nettype wire

// [hpb_pkg.sv]
// hpb_pkg: constants, types and register map of the handshake port block
// assumes a single 40 MHz clock and an avalon-mm master with waitrequest
package hpb_pkg;

  // register word offsets (byte addresses)
  localparam logic [3:0] CFG_OFS  = 4'h0;
  localparam logic [3:0] CMD_OFS  = 4'h4;
  localparam logic [3:0] DATA_OFS = 4'h8;
  localparam logic [3:0] PAT_OFS  = 4'hC;

  // cfg register field positions
  localparam int CFG_DIR_BIT  = 0;
  localparam int CFG_HS_LSB   = 1;
  localparam int CFG_TWO_BIT  = 3;
  localparam int CFG_SB_BIT   = 4;
  localparam int CFG_PMS_LSB  = 5;
  localparam int CFG_IMO_BIT  = 7;
  localparam int CFG_PEN_BIT  = 8;
  localparam int CFG_TEN_BIT  = 9;

  // cmd/status field positions
  localparam int ST_IRF_BIT  = 0;
  localparam int ST_ORE_BIT  = 1;
  localparam int ST_IP_BIT   = 2;
  localparam int ST_PMF_BIT  = 3;
  localparam int CMD_LSB     = 5;
  localparam logic [2:0] CMD_CLR_IP = 3'h5;

  // pat register field positions
  localparam int PAT_MASK_LSB = 8;

  // reset values
  localparam logic [9:0] CFG_RST = 10'h000;
  localparam logic [15:0] PAT_RST = 16'h0000;

  typedef enum logic [1:0] {HPB_INTERLOCKED, HPB_STROBED, HPB_PULSED, HPB_THREE_WIRE} hpb_hs_e;
  typedef enum logic [1:0] {HPB_PM_OFF, HPB_PM_AND, HPB_PM_OR, HPB_PM_ORPEV} hpb_pm_e;

  // first member is the top bit: listed from bit 9 down to bit 0
  typedef struct packed {
    logic       third_port_timer_enable;
    logic       first_port_enable;
    logic       match_only_interrupt;
    hpb_pm_e    pattern_mode_field;
    logic       single_buffer_select;
    logic       two_byte_interrupt;
    hpb_hs_e    hs_mode;
    logic       output_dir;
  } hpb_cfg_s;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } hpb_av_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } hpb_av_rsp_s;

  typedef struct packed {
    logic [7:0] pins_in;
    logic       ack_raw;
  } hpb_link_in_s;

  typedef struct packed {
    logic [7:0] pins_out;
    logic       pins_oe_n;
    logic       ready_for_data_line;
    logic       data_available_line;
  } hpb_link_out_s;

endpackage

// [hpb_port.sv]
// hpb_port: handshake and buffering logic of one 8-bit parallel port
// assumes the peripheral drives the acknowledge line asynchronously
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module hpb_port
  import hpb_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // avalon-mm slave
  input  wire hpb_pkg::hpb_av_req_s   av_req,
  output var  hpb_pkg::hpb_av_rsp_s   av_rsp,
  // peripheral link
  input  wire hpb_pkg::hpb_link_in_s  link_in,
  output var  hpb_pkg::hpb_link_out_s link_out,
  // interrupt request
  output logic                        irq
);
  import hpb_pkg::*;

  typedef struct packed {
    hpb_cfg_s   cfg;
    logic [7:0] pat_val;
    logic [7:0] pat_mask;
    logic [1:0] ack_sync;
    logic       ack_prev;
    logic [7:0] out_reg;
    logic       out_full;
    logic       wr_pending;
    logic [7:0] buf_reg;
    logic       buf_full;
    logic [7:0] in_reg;
    logic       input_full_flag;
    logic       ready_for_data_line;
    logic       data_available_line;
    logic       interrupt_pending;
    logic       pattern_match_flag;
    logic       match_irq;
    logic       ack_seen_low;
    logic [31:0] rdata;
    logic       rvalid;
  } hpb_state_s;

  hpb_state_s st;
  hpb_state_s next_st;

  // pattern compare; priority-vector mode has no meaning on output
  function automatic logic pat_hit(input logic [7:0] d, input logic [7:0] v,
                                   input logic [7:0] m, input hpb_pm_e pm);
    logic [7:0] eq;
    eq = ~(d ^ v) & m;
    unique case (pm)
      HPB_PM_AND:   pat_hit = (eq == m);
      HPB_PM_OR:    pat_hit = |eq;
      default:      pat_hit = 1'b0;
    endcase
  endfunction

  logic hs_run;
  logic ack_i;
  logic ack_fall;
  logic ack_rise;
  logic strobed;
  logic out_move;
  logic data_wr;
  logic cmd_wr;
  logic clr_cmd;
  logic hit;
  logic rd_en;
  logic pend_set;

  always_comb
  begin
    pend_set = 1'b0;
    hs_run   = st.cfg.third_port_timer_enable & st.cfg.first_port_enable;
    ack_i    = hs_run ? st.ack_sync[1] : 1'b1;
    ack_fall = st.ack_prev & ~ack_i;
    ack_rise = ~st.ack_prev & ack_i;
    strobed  = (st.cfg.hs_mode == HPB_STROBED);
    data_wr  = av_req.write & (av_req.address == DATA_OFS);
    cmd_wr   = av_req.write & (av_req.address == CMD_OFS);
    clr_cmd  = cmd_wr & (av_req.writedata[CMD_LSB +: 3] == CMD_CLR_IP);
    rd_en    = av_req.read & ~st.rvalid;
    hit      = pat_hit(st.out_reg, st.pat_val, st.pat_mask, st.cfg.pattern_mode_field);
    out_move = st.cfg.output_dir & hs_run & st.out_full & ~st.buf_full;

    next_st          = st;
    next_st.ack_sync = {st.ack_sync[0], link_in.ack_raw};
    next_st.ack_prev = ack_i;
    next_st.rvalid   = rd_en;

    if (av_req.write & (av_req.address == CFG_OFS))
    begin
      next_st.cfg = hpb_cfg_s'(av_req.writedata[9:0]);
    end
    if (av_req.write & (av_req.address == PAT_OFS))
    begin
      next_st.pat_val  = av_req.writedata[7:0];
      next_st.pat_mask = av_req.writedata[PAT_MASK_LSB +: 8];
    end

    if (!st.cfg.output_dir)
    begin
      // input path
      if (hs_run & ack_fall & ~st.buf_full)
      begin
        next_st.buf_reg  = link_in.pins_in;
        next_st.buf_full = 1'b1;
        next_st.ack_seen_low = 1'b1;
        next_st.ready_for_data_line = 1'b0;
      end
      else if (st.buf_full & ~st.input_full_flag)
      begin
        next_st.in_reg          = st.buf_reg;
        next_st.input_full_flag = 1'b1;
        next_st.buf_full        = 1'b0;
      end
      if (ack_rise)
      begin
        next_st.ack_seen_low = 1'b0;
      end
      if (hs_run & ~st.buf_full & ~next_st.buf_full & ~st.ready_for_data_line)
      begin
        if (strobed | ack_i)
        begin
          next_st.ready_for_data_line = 1'b1;
        end
      end
      if (!hs_run)
      begin
        next_st.ready_for_data_line = 1'b1;
      end
      // only a set flag is cleared, so a move in this cycle is not lost
      if (rd_en & (av_req.address == DATA_OFS) & st.input_full_flag)
      begin
        next_st.input_full_flag = 1'b0;
      end
      next_st.data_available_line = 1'b1;
    end
    else
    begin
      // output path; data-available is active low
      next_st.ready_for_data_line = 1'b1;
      if (out_move)
      begin
        next_st.buf_reg  = st.out_reg;
        next_st.buf_full = 1'b1;
        next_st.out_full = st.cfg.single_buffer_select;
        next_st.pattern_match_flag = hit;
        next_st.match_irq = hit | ~st.cfg.match_only_interrupt;
        // pending only on a real move
        if (!st.cfg.two_byte_interrupt && !st.cfg.single_buffer_select)
        begin
          next_st.interrupt_pending = 1'b1;
          pend_set = 1'b1;
        end
      end
      if (st.buf_full & st.data_available_line & ack_i & hs_run)
      begin
        next_st.data_available_line = 1'b0;
      end
      if (hs_run & ack_fall & st.buf_full & ~st.data_available_line)
      begin
        next_st.buf_full = 1'b0;
        next_st.data_available_line = 1'b1;
        if (st.cfg.single_buffer_select)
        begin
          next_st.out_full = 1'b0;
          next_st.interrupt_pending = 1'b1;
          pend_set = 1'b1;
        end
        else if (st.cfg.two_byte_interrupt & ~st.out_full)
        begin
          next_st.interrupt_pending = 1'b1;
          pend_set = 1'b1;
        end
      end
      if (!hs_run)
      begin
        next_st.data_available_line = 1'b1;
      end
      if (data_wr)
      begin
        next_st.out_reg = av_req.writedata[7:0];
        if (st.pattern_match_flag)
        begin
          next_st.wr_pending = 1'b1;
        end
        else
        begin
          next_st.out_full = 1'b1;
          // a pending set in this same cycle wins over the write
          next_st.interrupt_pending = pend_set;
        end
      end
      if ((data_wr | st.wr_pending) & st.pattern_match_flag & (clr_cmd | ~st.interrupt_pending))
      begin
        next_st.out_full   = 1'b1;
        next_st.wr_pending = 1'b0;
      end
    end

    if (clr_cmd & ~pend_set)
    begin
      next_st.interrupt_pending = 1'b0;
    end
    // disabled port cannot newly set pending
    if (!st.cfg.first_port_enable & ~st.interrupt_pending)
    begin
      next_st.interrupt_pending = 1'b0;
    end

    // readback
    if (rd_en)
    begin
      unique case (av_req.address)
        CFG_OFS:  next_st.rdata = {22'h0, st.cfg};
        CMD_OFS:  next_st.rdata = {28'h0, st.pattern_match_flag, st.interrupt_pending,
                                   ~st.out_full, st.input_full_flag};
        DATA_OFS: next_st.rdata = {24'h0, st.cfg.output_dir ? st.out_reg : st.in_reg};
        PAT_OFS:  next_st.rdata = {16'h0, st.pat_mask, st.pat_val};
        default:  next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= '0;
      st.cfg <= hpb_cfg_s'(CFG_RST);
      st.pat_val <= PAT_RST[7:0];
      st.pat_mask <= PAT_RST[15:8];
      st.ack_sync <= 2'h3;
      st.ack_prev <= 1'b1;
      st.ready_for_data_line <= 1'b1;
      st.data_available_line <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // reads answer one cycle later, writes at once
  always_comb
  begin
    av_rsp.waitrequest = av_req.read & ~st.rvalid;
    av_rsp.readdata    = st.rdata;
    link_out.pins_out  = st.buf_reg;
    link_out.pins_oe_n = ~(st.cfg.first_port_enable & st.cfg.output_dir);
    link_out.ready_for_data_line = st.ready_for_data_line;
    link_out.data_available_line = st.data_available_line;
    irq = st.interrupt_pending & st.cfg.first_port_enable & st.match_irq;
  end

  move_pend_a: assert property (@(posedge clk) disable iff (rst)
    out_move & ~st.cfg.two_byte_interrupt & ~st.cfg.single_buffer_select |=> st.interrupt_pending)
    else $error("pending not set after move");
  wr_clear_a: assert property (@(posedge clk) disable iff (rst)
    data_wr & st.cfg.output_dir & ~st.pattern_match_flag & ~out_move & ~ack_fall
    |=> ~st.interrupt_pending & st.out_full)
    else $error("write did not fill");
  dav_hold_a: assert property (@(posedge clk) disable iff (rst)
    st.cfg.output_dir & st.data_available_line & ~ack_i |=> st.data_available_line)
    else $error("data available fell with ack low");
  // interlocked ready stays low with ack low
  rfd_hold_a: assert property (@(posedge clk) disable iff (rst)
    ~st.cfg.output_dir & ~strobed & hs_run & ~st.ready_for_data_line & ~ack_i
    |=> ~st.ready_for_data_line)
    else $error("ready rose with ack low");
  // ack fall on idle input latches
  in_latch_a: assert property (@(posedge clk) disable iff (rst)
    ~st.cfg.output_dir & hs_run & ack_fall & ~st.buf_full
    |=> st.buf_full & ~st.ready_for_data_line)
    else $error("input latch missing");
  in_move_a: assert property (@(posedge clk) disable iff (rst)
    ~st.cfg.output_dir & st.buf_full & ~st.input_full_flag |=> st.input_full_flag)
    else $error("input full not set");
  idle_hs_a: assert property (@(posedge clk) disable iff (rst)
    ~st.cfg.third_port_timer_enable |-> ack_i & ~out_move)
    else $error("handshake not idle");
  irq_en_a: assert property (@(posedge clk) disable iff (rst)
    irq |-> st.cfg.first_port_enable & st.interrupt_pending)
    else $error("irq while disabled");
  strobe_rfd_a: assert property (@(posedge clk) disable iff (rst)
    ~st.cfg.output_dir & strobed & hs_run & ~st.buf_full & ~st.ready_for_data_line & ~ack_fall
    |=> st.ready_for_data_line)
    else $error("strobed ready did not rise");
  lock_rfd_a: assert property (@(posedge clk) disable iff (rst)
    ~st.cfg.output_dir & ~strobed & hs_run & ~st.buf_full & ~st.ready_for_data_line
    & ~ack_fall & ack_i |=> st.ready_for_data_line)
    else $error("interlocked ready did not rise");
  two_byte_a: assert property (@(posedge clk) disable iff (rst)
    st.cfg.output_dir & st.cfg.two_byte_interrupt & out_move & ~st.interrupt_pending
    |=> ~st.interrupt_pending)
    else $error("two-byte move set pending");
  match_upd_a: assert property (@(posedge clk) disable iff (rst)
    out_move |=> st.pattern_match_flag == $past(hit))
    else $error("match flag not updated at move");
  // output byte taken by ack fall
  sequence ack_taken_s;
    hs_run & ack_fall & st.buf_full & ~st.data_available_line;
  endsequence
  take_out_a: assert property (@(posedge clk) disable iff (rst)
    st.cfg.output_dir ##0 ack_taken_s |=> st.data_available_line)
    else $error("data available not released");
  sb_empty_a: assert property (@(posedge clk) disable iff (rst)
    (st.cfg.output_dir & st.cfg.single_buffer_select & ~data_wr & ~st.wr_pending)
    ##0 ack_taken_s |=> st.interrupt_pending & ~st.out_full)
    else $error("single buffer not emptied");
  cmd_clear_a: assert property (@(posedge clk) disable iff (rst)
    clr_cmd & ~pend_set |=> ~st.interrupt_pending)
    else $error("command did not clear pending");
  dis_pend_a: assert property (@(posedge clk) disable iff (rst)
    ~st.cfg.first_port_enable & ~st.interrupt_pending |=> ~st.interrupt_pending)
    else $error("pending set while disabled");

endmodule

`default_nettype wire
